/* File: psc_pkg.sv */
/*
  Package of the CPU processing-state controller: register map, field
  positions, reset values, state and exception encodings, carrier structs.
  Assumes a single 40 MHz system clock and a 32-bit AHB-Lite register port.
*/
package psc_pkg;

  // Register byte offsets
  localparam logic [7:0] PSC_CTRL_OFS   = 8'h00;
  localparam logic [7:0] PSC_EXTCTL_OFS = 8'h04;
  localparam logic [7:0] PSC_EVENT_OFS  = 8'h08;
  localparam logic [7:0] PSC_STATUS_OFS = 8'h0c;
  localparam logic [7:0] PSC_VECTOR_OFS = 8'h10;
  localparam logic [7:0] PSC_ACCESS_OFS = 8'h14;

  // Control register fields
  localparam int CTRL_SOFTWARE_STANDBY_SELECT_BIT   = 0;
  localparam int CTRL_LOW_SPEED_ON_FLAG_BIT   = 1;
  localparam int CTRL_PSS_BIT    = 2;
  localparam int CTRL_ICMODE_BIT = 4;
  localparam int CTRL_MSPEED_BIT = 8;
  localparam int CTRL_MSTOP_LSB  = 16;
  localparam int CTRL_MSTOP_W    = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Extended control register fields
  localparam int EXT_MASK_LSB   = 0;
  localparam int EXT_TRACE_BIT  = 7;
  localparam logic [7:0] EXT_RESET = 8'h07;
  localparam logic [2:0] MASK_ALL  = 3'h7;

  // Event register command bits (write-one pulses)
  localparam int EV_INSN_END  = 0;
  localparam int EV_TRAP      = 1;
  localparam int EV_SLEEP     = 2;
  localparam int EV_RTE       = 3;
  localparam int EV_CTL_INSN  = 4;
  localparam int EV_WDT_OVF   = 5;
  localparam int EV_IRQ_LSB   = 8;
  localparam int IRQ_LVL_W    = 3;
  localparam int EV_WAKE      = 12;

  // Access-cycle register fields
  localparam int ACC_SPACE_LSB = 0;
  localparam int ACC_WIDE_BIT  = 2;
  localparam int ACC_THREE_BIT = 3;
  localparam int ACC_WAIT_LSB  = 4;
  localparam int ACC_WAIT_W    = 4;

  // Vector addresses
  localparam logic [7:0] VEC_RESET = 8'h00;
  localparam logic [7:0] VEC_TRACE = 8'h14;
  localparam logic [7:0] VEC_IRQ   = 8'h40;
  localparam logic [7:0] VEC_TRAP  = 8'h20;

  // Context push length in states
  localparam logic [2:0] PUSH_STATES  = 3'h4;

  // Access space codes and state counts
  localparam logic [1:0] SPACE_MEM = 2'h0;
  localparam logic [1:0] SPACE_MOD = 2'h1;
  localparam logic [1:0] SPACE_EXT = 2'h2;
  localparam logic [3:0] MEM_STATES = 4'h1;
  localparam logic [3:0] MOD_STATES = 4'h2;
  localparam logic [3:0] EXT2_STATES = 4'h2;
  localparam logic [3:0] EXT3_STATES = 4'h3;

  typedef enum logic [2:0] {
    PST_RESET, PST_EXCEPTION, PST_EXECUTE, PST_BUS_RELEASED,
    PST_SLEEP, PST_SW_STANDBY, PST_HW_STANDBY
  } psc_state_t;

  typedef enum logic [2:0] {
    EXC_NONE, EXC_RESET, EXC_TRACE, EXC_IRQ, EXC_TRAP
  } psc_exc_t;

  typedef enum logic [1:0] {
    SEQ_IDLE, SEQ_PUSH, SEQ_MASK, SEQ_VECTOR
  } psc_seq_t;

  // Power and clock controls going to the rest of the chip
  typedef struct packed {
    logic                      cpu_halt;
    logic                      clock_stop;
    logic                      module_reset;
    logic                      medium_speed;
    logic [CTRL_MSTOP_W-1:0]   module_stop;
  } psc_power_t;

  // Bus-cycle shape for the current access
  typedef struct packed {
    logic [3:0] states;
    logic       wide;
  } psc_access_t;

endpackage

/* File: psc_ctrl.sv */
/*
  CPU processing-state controller: reset, exception, execution,
  bus-released and power-down sequencing, with an AHB-Lite register port.
  Assumes clear and standby pins are synchronous to clk_sys and the
  instruction core reports instruction events through the event register.
*/
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
module psc_ctrl
  import psc_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 arst_n,
  // Pins
  input  wire logic                 power_on_clear_pin_n,
  input  wire logic                 manual_clear_pin_n,
  input  wire logic                 hardware_standby_pin_n,
  input  wire logic                 irq_nmi,
  // Other bus masters
  input  wire logic                 bus_request,
  output logic                      bus_grant,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Status to the chip
  output psc_pkg::psc_state_t       cpu_state,
  output psc_pkg::psc_power_t       power_ctl,
  output psc_pkg::psc_access_t      access_shape,
  output logic [7:0]                vector_addr,
  output logic                      vector_fetch,
  output logic                      manual_reset
);
  import psc_pkg::*;

  // Bus front end
  logic        wr_pend, next_wr_pend;
  logic [7:0]  wr_addr, next_wr_addr;
  logic [31:0] next_hrdata;
  logic        take;

  // Block state
  psc_state_t  state, next_state;
  psc_exc_t    exc, next_exc;
  psc_seq_t    seq, next_seq;
  logic [2:0]  cnt, next_cnt;
  logic [31:0] ctrl, next_ctrl;
  logic [7:0]  extctl, next_extctl;
  logic [7:0]  stacked_ext, next_stacked_ext;
  logic [7:0]  access_cfg, next_access_cfg;
  logic        por_q, manual_clear_pin_n_q, next_manual;
  logic        irq_block, next_irq_block;
  logic        next_grant;
  // Level of the interrupt in service; its event pulse is gone by the mask step
  logic [2:0]  pend_lvl, next_pend_lvl;
  logic [7:0]  next_vec;
  logic        next_vfetch;
  psc_power_t  next_power;
  psc_access_t next_shape;

  // Event decode
  logic       ev_wr, insn_end, ev_trap, ev_sleep, ev_rte, ev_ctl, ev_wdt, ev_wake;
  logic [2:0] irq_lvl;
  logic       trace_ok, irq_ok;

  function automatic psc_access_t shape_of(input logic [7:0] cfg);
    psc_access_t s;
    s.wide = cfg[ACC_WIDE_BIT];
    case (cfg[ACC_SPACE_LSB +: 2])
      SPACE_MEM: begin
        s.states = MEM_STATES;
        s.wide   = 1'b1;
      end
      SPACE_MOD: s.states = MOD_STATES;
      SPACE_EXT: s.states = cfg[ACC_THREE_BIT] ?
                            EXT3_STATES + cfg[ACC_WAIT_LSB +: ACC_WAIT_W] :
                            EXT2_STATES;
      default:   s.states = MEM_STATES;
    endcase
    return s;
  endfunction

  // Hreadyout tied high: zero wait states, every phase lasts one cycle
  assign take     = hsel && hready && htrans[1];
  assign ev_wr    = wr_pend && (wr_addr == PSC_EVENT_OFS);
  assign insn_end = ev_wr && hwdata[EV_INSN_END];
  assign ev_trap  = ev_wr && hwdata[EV_TRAP];
  assign ev_sleep = ev_wr && hwdata[EV_SLEEP];
  assign ev_rte   = ev_wr && hwdata[EV_RTE];
  assign ev_ctl   = ev_wr && hwdata[EV_CTL_INSN];
  assign ev_wdt   = ev_wr && hwdata[EV_WDT_OVF];
  assign ev_wake  = ev_wr && hwdata[EV_WAKE];
  assign irq_lvl  = ev_wr ? hwdata[EV_IRQ_LSB +: IRQ_LVL_W] : 3'h0;

  // Trace needs mode 2 and no return-from-exception at this end
  assign trace_ok = extctl[EXT_TRACE_BIT] && ctrl[CTRL_ICMODE_BIT]
                    && !ev_rte;
  assign irq_ok   = !irq_block && !ev_ctl &&
                    (irq_nmi || (irq_lvl > extctl[EXT_MASK_LSB +: 3]));

  always_comb begin
    next_wr_pend = take && hwrite;
    next_wr_addr = take ? haddr[7:0] : wr_addr;
    next_hrdata  = hrdata;
    if (take && !hwrite) begin
      case (haddr[7:0])
        PSC_CTRL_OFS:   next_hrdata = ctrl;
        PSC_EXTCTL_OFS: next_hrdata = {24'h0, extctl};
        PSC_STATUS_OFS: next_hrdata = {16'h0, stacked_ext, 1'b0, exc, 1'b0, state};
        PSC_VECTOR_OFS: next_hrdata = {24'h0, vector_addr};
        PSC_ACCESS_OFS: next_hrdata = {24'h0, access_cfg};
        default:        next_hrdata = 32'h0;
      endcase
    end
  end

  always_comb begin
    next_state       = state;
    next_exc         = exc;
    next_seq         = seq;
    next_cnt         = cnt;
    next_ctrl        = ctrl;
    next_extctl      = extctl;
    next_stacked_ext = stacked_ext;
    next_access_cfg  = access_cfg;
    next_manual      = manual_reset;
    next_irq_block   = irq_block;
    next_pend_lvl    = pend_lvl;
    next_grant       = 1'b0;
    next_vec         = vector_addr;
    next_vfetch      = 1'b0;

    if (wr_pend && wr_addr == PSC_CTRL_OFS)
      next_ctrl = hwdata;
    if (wr_pend && wr_addr == PSC_EXTCTL_OFS)
      next_extctl = hwdata[7:0];
    if (wr_pend && wr_addr == PSC_ACCESS_OFS)
      next_access_cfg = hwdata[7:0];

    case (state)
      PST_RESET: begin
        // Interrupts stay off until the first ordinary instruction end
        next_irq_block = 1'b1;
        next_extctl    = EXT_RESET;
        if (!power_on_clear_pin_n)
          next_manual = 1'b0;
        else if (!manual_clear_pin_n)
          next_manual = 1'b1;
        // Clocked rising edge of whichever pin held the reset
        if ((!por_q || !manual_clear_pin_n_q) && power_on_clear_pin_n && manual_clear_pin_n) begin
          next_state = PST_EXCEPTION;
          next_exc   = EXC_RESET;
          next_seq   = SEQ_VECTOR;
        end
      end
      PST_EXCEPTION: begin
        case (seq)
          SEQ_PUSH: begin
            next_cnt = cnt + 3'h1;
            if (cnt == PUSH_STATES - 3'h1) begin
              next_stacked_ext = extctl;
              next_seq         = SEQ_MASK;
            end
          end
          SEQ_MASK: begin
            if (exc == EXC_IRQ)
              next_extctl[EXT_MASK_LSB +: 3] = pend_lvl;
            if (exc == EXC_TRACE)
              next_extctl[EXT_TRACE_BIT] = 1'b0;
            next_seq = SEQ_VECTOR;
          end
          SEQ_VECTOR: begin
            case (exc)
              EXC_RESET: next_vec = VEC_RESET;
              EXC_TRACE: next_vec = VEC_TRACE;
              EXC_IRQ:   next_vec = VEC_IRQ;
              EXC_TRAP:  next_vec = VEC_TRAP;
              default:   next_vec = VEC_RESET;
            endcase
            next_vfetch = 1'b1;
            next_seq    = SEQ_IDLE;
            next_exc    = EXC_NONE;
            // Sequence end: trace then interrupt may chain
            if (trace_ok && exc != EXC_TRACE) begin
              next_exc = EXC_TRACE;
              next_seq = SEQ_PUSH;
              next_cnt = 3'h0;
            end else if (irq_ok && exc != EXC_RESET) begin
              next_exc = EXC_IRQ;
              next_pend_lvl = irq_nmi ? MASK_ALL : irq_lvl;
              next_seq = SEQ_PUSH;
              next_cnt = 3'h0;
            end else begin
              next_state = PST_EXECUTE;
            end
          end
          default: next_seq = SEQ_IDLE;
        endcase
      end
      PST_EXECUTE: begin
        if (insn_end && !ev_ctl)
          next_irq_block = 1'b0;
        // Bus release outranks trace, interrupt and trap (not the watchdog reset below): nothing runs without the bus
        if (bus_request) begin
          next_state = PST_BUS_RELEASED;
          next_grant = 1'b1;
        end else if (insn_end && trace_ok) begin
          next_state = PST_EXCEPTION;
          next_exc   = EXC_TRACE;
          next_seq   = SEQ_PUSH;
          next_cnt   = 3'h0;
        end else if (insn_end && irq_ok) begin
          next_pend_lvl = irq_nmi ? MASK_ALL : irq_lvl;
          next_state = PST_EXCEPTION;
          next_exc   = EXC_IRQ;
          next_seq   = SEQ_PUSH;
          next_cnt   = 3'h0;
        end else if (ev_trap) begin
          next_state = PST_EXCEPTION;
          next_exc   = EXC_TRAP;
          next_seq   = SEQ_PUSH;
          next_cnt   = 3'h0;
        end else if (ev_sleep && !ctrl[CTRL_LOW_SPEED_ON_FLAG_BIT]) begin
          // Low-speed-on set: sleep is left to the low-speed logic outside
          if (!ctrl[CTRL_SOFTWARE_STANDBY_SELECT_BIT])
            next_state = PST_SLEEP;
          else if (!ctrl[CTRL_PSS_BIT])
            next_state = PST_SW_STANDBY;
        end
      end
      PST_BUS_RELEASED: begin
        next_grant = bus_request;
        if (!bus_request)
          next_state = PST_EXECUTE;
      end
      PST_SLEEP, PST_SW_STANDBY: begin
        if (ev_wake || irq_nmi)
          next_state = PST_EXECUTE;
      end
      PST_HW_STANDBY: begin
        // Supporting settings back to reset; RAM contents live outside
        next_ctrl       = CTRL_RESET;
        next_access_cfg = 8'h0;
      end
      default: next_state = PST_RESET;
    endcase

    // Overriding entries, lowest first: a later entry wins over an earlier one
    if (ev_wdt && state != PST_RESET && state != PST_HW_STANDBY) begin
      next_state     = PST_EXCEPTION;
      next_exc       = EXC_RESET;
      next_seq       = SEQ_VECTOR;
      next_irq_block = 1'b1;
      next_extctl    = EXT_RESET;
      // A grant cannot outlive the CPU leaving execution
      next_grant     = 1'b0;
    end
    if (!power_on_clear_pin_n || !manual_clear_pin_n) begin
      next_state = PST_RESET;
      // Flag moves with the state, so both read alike at the next edge
      next_manual = power_on_clear_pin_n;
      next_exc   = EXC_NONE;
      next_seq   = SEQ_IDLE;
      next_grant = 1'b0;
    end
    if (!hardware_standby_pin_n) begin
      next_state = PST_HW_STANDBY;
      next_grant = 1'b0;
    end else if (state == PST_HW_STANDBY && power_on_clear_pin_n && manual_clear_pin_n) begin
      // Pins already high: no clear edge follows, so reset handling starts here
      next_state     = PST_EXCEPTION;
      next_exc       = EXC_RESET;
      next_seq       = SEQ_VECTOR;
      next_irq_block = 1'b1;
      next_extctl    = EXT_RESET;
    end

    next_power.cpu_halt     = (next_state == PST_SLEEP) || (next_state == PST_SW_STANDBY)
                              || (next_state == PST_HW_STANDBY)
                              || (next_state == PST_BUS_RELEASED);
    next_power.clock_stop   = (next_state == PST_SW_STANDBY)
                              || (next_state == PST_HW_STANDBY);
    next_power.module_reset = (next_state == PST_HW_STANDBY);
    next_power.medium_speed = next_ctrl[CTRL_MSPEED_BIT];
    next_power.module_stop  = next_ctrl[CTRL_MSTOP_LSB +: CTRL_MSTOP_W];
    next_shape              = shape_of(next_access_cfg);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend      <= 1'b0;
      wr_addr      <= 8'h0;
      hrdata       <= 32'h0;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      state        <= PST_RESET;
      exc          <= EXC_NONE;
      seq          <= SEQ_IDLE;
      cnt          <= 3'h0;
      ctrl         <= CTRL_RESET;
      extctl       <= EXT_RESET;
      stacked_ext  <= 8'h0;
      access_cfg   <= 8'h0;
      por_q        <= 1'b0;
      manual_clear_pin_n_q       <= 1'b1;
      manual_reset <= 1'b0;
      irq_block    <= 1'b1;
      pend_lvl     <= 3'h0;
      bus_grant    <= 1'b0;
      vector_addr  <= 8'h0;
      vector_fetch <= 1'b0;
      cpu_state    <= PST_RESET;
      power_ctl    <= '0;
      access_shape <= '0;
    end else begin
      wr_pend      <= next_wr_pend;
      wr_addr      <= next_wr_addr;
      hrdata       <= next_hrdata;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      state        <= next_state;
      exc          <= next_exc;
      seq          <= next_seq;
      cnt          <= next_cnt;
      ctrl         <= next_ctrl;
      extctl       <= next_extctl;
      stacked_ext  <= next_stacked_ext;
      access_cfg   <= next_access_cfg;
      por_q        <= power_on_clear_pin_n;
      manual_clear_pin_n_q       <= manual_clear_pin_n;
      manual_reset <= next_manual;
      irq_block    <= next_irq_block;
      pend_lvl     <= next_pend_lvl;
      bus_grant    <= next_grant;
      vector_addr  <= next_vec;
      vector_fetch <= next_vfetch;
      cpu_state    <= next_state;
      power_ctl    <= next_power;
      access_shape <= next_shape;
    end
  end

endmodule

/* File: psc_checker.sv */
/*
  Port-level checks for the processing-state controller, bound to psc_ctrl.
  Assumes one clk_sys domain and an asynchronous active-low arst_n.
*/
`timescale 1ns/10ps
module psc_checker
  import psc_pkg::*;
(
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       arst_n,
  // Pins and other masters
  input wire logic       power_on_clear_pin_n,
  input wire logic       manual_clear_pin_n,
  input wire logic       hardware_standby_pin_n,
  input wire logic       bus_request,
  input wire logic       bus_grant,
  // Status
  input wire psc_state_t cpu_state,
  input wire psc_power_t power_ctl,
  input wire logic [7:0] vector_addr,
  input wire logic       vector_fetch,
  input wire logic       manual_reset
);
  import psc_pkg::*;
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire logic pins_up = power_on_clear_pin_n && manual_clear_pin_n && hardware_standby_pin_n;

  por_enter_a: assert property (!power_on_clear_pin_n |=> cpu_state == PST_RESET)
    else $error("power-on clear did not enter reset");
  manual_enter_a: assert property (!manual_clear_pin_n && power_on_clear_pin_n
    && hardware_standby_pin_n |=> cpu_state == PST_RESET && manual_reset)
    else $error("manual clear did not enter manual reset");
  reset_start_a: assert property (cpu_state == PST_RESET && pins_up
    |-> ##[1:2] cpu_state == PST_EXCEPTION)
    else $error("reset handling did not start after clear pins rose");
  fetch_source_a: assert property ($rose(vector_fetch) |-> $past(cpu_state) == PST_EXCEPTION)
    else $error("vector fetched outside exception handling");
  exc_bound_a: assert property (cpu_state == PST_EXCEPTION |-> ##[1:7] cpu_state != PST_EXCEPTION)
    else $error("exception sequence too long");
  grant_given_a: assert property (cpu_state == PST_EXECUTE && bus_request && pins_up
    |-> ##[1:2] bus_grant)
    else $error("bus request not granted");
  grant_halt_a: assert property (bus_grant |-> cpu_state == PST_BUS_RELEASED && !vector_fetch)
    else $error("cpu active while bus released");
  sleep_halt_a: assert property (cpu_state == PST_SLEEP |-> power_ctl.cpu_halt)
    else $error("sleep without cpu halt");
  standby_clock_a: assert property (cpu_state == PST_SW_STANDBY
    |-> power_ctl.cpu_halt && power_ctl.clock_stop)
    else $error("software standby without clock stop");
  hw_standby_a: assert property (!hardware_standby_pin_n && power_on_clear_pin_n
    |=> cpu_state == PST_HW_STANDBY && power_ctl.clock_stop && power_ctl.module_reset)
    else $error("hardware standby not entered");

  cover property (bus_grant);
  cover property (vector_fetch && vector_addr == VEC_TRACE);
  cover property (cpu_state == PST_HW_STANDBY);
endmodule

bind psc_ctrl psc_checker chk_i (.*);

/* File: psc_far_master.sv */
/*
  Model of another bus master facing the controller.
  Assumes the bench raises want_bus and drops it once the grant is seen.
*/
`timescale 1ns/10ps
module psc_far_master #(
  parameter int HOLD = 5
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // Handshake
  input  wire logic want_bus,
  input  wire logic bus_grant,
  output logic      bus_request
);
  logic [3:0] held;

  // Request held through the grant until our own transfers are done
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bus_request <= 1'b0;
      held        <= 4'h0;
    end else if (bus_request && bus_grant) begin
      held <= held + 4'h1;
      if (held == 4'(HOLD)) begin
        bus_request <= 1'b0;
        held        <= 4'h0;
      end
    end else if (!bus_request) begin
      bus_request <= want_bus;
    end
  end
endmodule

/* File: psc_ctrl_tb_top.sv */
/*
  Self-checking bench of the processing-state controller.
  Assumes a single AHB-Lite master here and the far-side bus master model.
*/
`timescale 1ns/10ps
module psc_ctrl_tb_top;
  import psc_pkg::*;
  logic        clk_sys = 1'b0, arst_n = 1'b0, irq_nmi = 1'b0, want_bus = 1'b0;
  logic        power_on_clear_pin_n = 1'b1, manual_clear_pin_n = 1'b1;
  logic        hardware_standby_pin_n = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic        bus_request, bus_grant, hreadyout, hresp, vector_fetch, manual_reset;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  vector_addr;
  wire logic   hready = hreadyout;
  psc_state_t  cpu_state;
  psc_power_t  power_ctl;
  psc_access_t access_shape;
  int          num_errors = 0, n_compared = 0;

  always #12.5 clk_sys = ~clk_sys;

  psc_ctrl dut (.*);
  psc_far_master far (.clk_sys, .arst_n, .want_bus, .bus_grant, .bus_request);

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wait_vec(input logic [7:0] e);
    int i;
    for (i = 0; i < 30 && vector_fetch !== 1'b1; i++) @(posedge clk_sys);
    chk("vector_fetch", 32'h1, {31'h0, vector_fetch});
    chk("vector_addr", {24'h0, e}, {24'h0, vector_addr});
    repeat (12) @(posedge clk_sys);
  endtask

  task automatic no_vec();
    int hits;
    hits = 0;
    repeat (12) begin
      @(posedge clk_sys);
      if (vector_fetch === 1'b1) hits++;
    end
    chk("vector_quiet", 32'h0, hits);
  endtask

  task automatic wait_st(input psc_state_t st);
    int i;
    for (i = 0; i < 40 && cpu_state !== st; i++) @(posedge clk_sys);
    chk("cpu_state", {29'h0, st}, {29'h0, cpu_state});
  endtask

  task automatic t_exceptions();
    bus(0, PSC_EXTCTL_OFS, 0);
    chk("ext_reset", {24'h0, EXT_RESET}, q);
    bus(1, PSC_EVENT_OFS, 32'h1 << EV_TRAP);
    wait_vec(VEC_TRAP);
    bus(0, PSC_STATUS_OFS, 0);
    chk("stacked_ext", {24'h0, EXT_RESET}, {24'h0, q[15:8]});
    bus(1, PSC_CTRL_OFS, 32'h1 << CTRL_ICMODE_BIT);
    bus(1, PSC_EXTCTL_OFS, 32'h83);
    bus(1, PSC_EVENT_OFS, 32'h1 << EV_INSN_END);
    wait_vec(VEC_TRACE);
    bus(0, PSC_EXTCTL_OFS, 0);
    chk("trace_cleared", 32'h03, q);
    bus(0, PSC_STATUS_OFS, 0);
    chk("stacked_trace", 32'h83, {24'h0, q[15:8]});
    bus(1, PSC_EXTCTL_OFS, 32'h83);
    bus(1, PSC_EVENT_OFS, (32'h1 << EV_RTE) | (32'h1 << EV_INSN_END));
    no_vec();
    bus(1, PSC_EXTCTL_OFS, 32'h80);
    bus(1, PSC_EVENT_OFS, (32'h5 << EV_IRQ_LSB) | (32'h1 << EV_INSN_END));
    wait_vec(VEC_TRACE);
    bus(1, PSC_CTRL_OFS, 32'h0);
    bus(1, PSC_EXTCTL_OFS, 32'h87);
    bus(1, PSC_EVENT_OFS, 32'h1 << EV_INSN_END);
    no_vec();
    bus(1, PSC_EXTCTL_OFS, 32'h02);
    bus(1, PSC_EVENT_OFS, 32'h5 << EV_IRQ_LSB);
    no_vec();
    bus(1, PSC_EVENT_OFS, (32'h5 << EV_IRQ_LSB) | (32'h1 << EV_CTL_INSN) | 32'h1);
    no_vec();
    bus(1, PSC_EVENT_OFS, (32'h5 << EV_IRQ_LSB) | (32'h1 << EV_INSN_END));
    wait_vec(VEC_IRQ);
    bus(0, PSC_STATUS_OFS, 0);
    chk("stacked_irq", 32'h02, {24'h0, q[15:8]});
  endtask

  task automatic t_access();
    logic [7:0] cfg [5] = '{8'h00, 8'h01, 8'h32, 8'h2e, 8'h0a};
    logic [3:0] n;
    foreach (cfg[i]) begin
      bus(1, PSC_ACCESS_OFS, {24'h0, cfg[i]});
      repeat (2) @(posedge clk_sys);
      n = cfg[i][1:0] == SPACE_MEM ? MEM_STATES : cfg[i][1:0] == SPACE_MOD ? MOD_STATES :
          cfg[i][3] ? EXT3_STATES + cfg[i][7:4] : EXT2_STATES;
      chk("access_shape", {27'h0, n, cfg[i][1:0] == SPACE_MEM || cfg[i][2]},
          {27'h0, access_shape});
    end
  endtask

  task automatic t_power();
    want_bus <= 1'b1;
    wait_st(PST_BUS_RELEASED);
    want_bus <= 1'b0;
    wait_st(PST_EXECUTE);
    bus(1, PSC_EVENT_OFS, 32'h1 << EV_SLEEP);
    wait_st(PST_SLEEP);
    bus(0, PSC_EXTCTL_OFS, 0);
    chk("regs_kept", 32'h05, q);
    bus(1, PSC_EVENT_OFS, 32'h1 << EV_WAKE);
    wait_st(PST_EXECUTE);
    bus(1, PSC_CTRL_OFS, 32'h1 << CTRL_SOFTWARE_STANDBY_SELECT_BIT);
    bus(1, PSC_EVENT_OFS, 32'h1 << EV_SLEEP);
    wait_st(PST_SW_STANDBY);
    chk("clock_stop", 32'h1, {31'h0, power_ctl.clock_stop});
    irq_nmi <= 1'b1;
    @(posedge clk_sys);
    irq_nmi <= 1'b0;
    wait_st(PST_EXECUTE);
    repeat (12) @(posedge clk_sys);
    bus(1, PSC_CTRL_OFS, (32'h1 << CTRL_MSPEED_BIT) | (32'ha5 << CTRL_MSTOP_LSB));
    repeat (2) @(posedge clk_sys);
    chk("medium_stop", 32'h1a5, {23'h0, power_ctl.medium_speed, power_ctl.module_stop});
    bus(1, PSC_CTRL_OFS, 32'h0);
    hardware_standby_pin_n <= 1'b0;
    wait_st(PST_HW_STANDBY);
    chk("module_reset", 32'h1, {31'h0, power_ctl.module_reset});
    hardware_standby_pin_n <= 1'b1;
    wait_st(PST_EXECUTE);
  endtask

  task automatic t_resets();
    bus(1, PSC_EVENT_OFS, 32'h1 << EV_WDT_OVF);
    wait_vec(VEC_RESET);
    wait_st(PST_EXECUTE);
    irq_nmi <= 1'b1;
    manual_clear_pin_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("manual_state", {29'h0, PST_RESET}, {29'h0, cpu_state});
    chk("manual_flag", 32'h1, {31'h0, manual_reset});
    manual_clear_pin_n <= 1'b1;
    wait_st(PST_EXECUTE);
    no_vec();
    irq_nmi <= 1'b0;
    power_on_clear_pin_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("por_flag", 32'h0, {31'h0, manual_reset});
    power_on_clear_pin_n <= 1'b1;
    wait_st(PST_EXECUTE);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    wait_st(PST_EXECUTE);
  endtask

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    wait_st(PST_EXECUTE);
    t_exceptions();
    t_access();
    t_power();
    t_resets();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    complete_run();
  end
endmodule
